/* File: src/rcwg_params.svh */
// constants for the receive condition write guard
//
// Summary of operation
// R1: host reads condition A before writing it
// R2: read of condition A loads snapshot A
// R3: mismatching A bits blocked, inhibit flag raised
// R4: read of condition B loads snapshot B
// R5: mismatching B bits blocked, inhibit flag raised
// R6: snapshot A at 1Ch, always read/write
// R7: snapshot B at 1Dh, always read/write
// R8: snapshot B bit 7 guards reserved bit
// R9: matching bits take written value, per bit
`ifndef RCWG_PARAMS_SVH
`define RCWG_PARAMS_SVH

// ----------------------------------------------------------------
// control bus addresses
// ----------------------------------------------------------------
`define RCWG_ADDR_W 6
`define RCWG_ADDR_SNAP_A 6'h1C
`define RCWG_ADDR_SNAP_B 6'h1D
`define RCWG_ADDR_COND_A 6'h0A
`define RCWG_ADDR_COND_B 6'h0B

// ----------------------------------------------------------------
// data layout and reset values
// ----------------------------------------------------------------
`define RCWG_DATA_W 8
`define RCWG_SNAP_A_RST 8'h00
`define RCWG_SNAP_B_RST 8'h00
`define RCWG_RDATA_RST 8'h00
`define RCWG_RESV_BIT_B 7

`endif

/* File: src/rcwg_pkg.sv */
// types for the receive condition write guard
package rcwg_pkg;

    // one control bus access, valid for a single cycle
    typedef struct packed {
        logic sel;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } rcwg_cbus_req_t;

    // guarded write handed to a receive condition register
    typedef struct packed {
        logic wr;
        logic [7:0] mask;
        logic [7:0] data;
    } rcwg_cond_wr_t;

    // decoded access kind
    typedef enum logic [2:0] {
        RCWG_ACC_NONE = 3'b000,
        RCWG_ACC_RD_COND = 3'b001,
        RCWG_ACC_WR_COND = 3'b010,
        RCWG_ACC_RD_SNAP = 3'b011,
        RCWG_ACC_WR_SNAP = 3'b100
    } rcwg_acc_t;

endpackage

/* File: src/rcwg_guard.sv */
// read-before-write guard for receive condition registers a and b
`timescale 1ns/1ps
`default_nettype none
`include "rcwg_params.svh"

module rcwg_guard (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire rcwg_pkg::rcwg_cbus_req_t cbus_req_in,
    input wire logic [7:0] rcv_a_in,
    input wire logic [7:0] rcv_b_in,
    output logic [7:0] rdata_out,
    output logic rdata_hit_out,
    output rcwg_pkg::rcwg_cond_wr_t rcv_a_wr_out,
    output rcwg_pkg::rcwg_cond_wr_t rcv_b_wr_out,
    output logic write_inhibit_set_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] receive_cond_a_snapshot;
    logic [7:0] receive_cond_b_snapshot;
    logic [7:0] mismatch_a;
    logic [7:0] mismatch_b;
    logic [7:0] next_data_a;
    logic [7:0] next_data_b;
    logic hit_a;
    logic hit_b;
    logic hit_snap_a;
    logic hit_snap_b;
    rcwg_pkg::rcwg_acc_t acc_a;
    rcwg_pkg::rcwg_acc_t acc_b;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign hit_a = cbus_req_in.sel &&
                   (cbus_req_in.addr == `RCWG_ADDR_COND_A);
    assign hit_b = cbus_req_in.sel &&
                   (cbus_req_in.addr == `RCWG_ADDR_COND_B);
    assign hit_snap_a = cbus_req_in.sel &&
                        (cbus_req_in.addr == `RCWG_ADDR_SNAP_A);
    assign hit_snap_b = cbus_req_in.sel &&
                        (cbus_req_in.addr == `RCWG_ADDR_SNAP_B);

    always_comb begin
        if (hit_a) begin
            acc_a = cbus_req_in.wr ? rcwg_pkg::RCWG_ACC_WR_COND :
                                     rcwg_pkg::RCWG_ACC_RD_COND;
        end else if (hit_snap_a) begin
            acc_a = cbus_req_in.wr ? rcwg_pkg::RCWG_ACC_WR_SNAP :
                                     rcwg_pkg::RCWG_ACC_RD_SNAP;
        end else begin
            acc_a = rcwg_pkg::RCWG_ACC_NONE;
        end
    end

    always_comb begin
        if (hit_b) begin
            acc_b = cbus_req_in.wr ? rcwg_pkg::RCWG_ACC_WR_COND :
                                     rcwg_pkg::RCWG_ACC_RD_COND;
        end else if (hit_snap_b) begin
            acc_b = cbus_req_in.wr ? rcwg_pkg::RCWG_ACC_WR_SNAP :
                                     rcwg_pkg::RCWG_ACC_RD_SNAP;
        end else begin
            acc_b = rcwg_pkg::RCWG_ACC_NONE;
        end
    end

    // ------------------------------------------------------------
    // bit merge
    // ------------------------------------------------------------
    // R3: live bits differing from snapshot a
    assign mismatch_a = rcv_a_in ^ receive_cond_a_snapshot;
    // R5: live bits differing from snapshot b
    // R8: bit 7 guards the reserved bit too
    assign mismatch_b = rcv_b_in ^ receive_cond_b_snapshot;
    // R9: per-bit keep or take
    assign next_data_a = (rcv_a_in & mismatch_a) |
                         (cbus_req_in.wdata & ~mismatch_a);
    assign next_data_b = (rcv_b_in & mismatch_b) |
                         (cbus_req_in.wdata & ~mismatch_b);

    // ------------------------------------------------------------
    // snapshot a
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            receive_cond_a_snapshot <= `RCWG_SNAP_A_RST;
        end else begin
            case (acc_a)
                // R2: read of condition a copies it
                rcwg_pkg::RCWG_ACC_RD_COND: begin
                    receive_cond_a_snapshot <= rcv_a_in;
                end
                // R6: direct write at 1Ch
                rcwg_pkg::RCWG_ACC_WR_SNAP: begin
                    receive_cond_a_snapshot <= cbus_req_in.wdata;
                end
                default: begin
                    receive_cond_a_snapshot <= receive_cond_a_snapshot;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // snapshot b
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            receive_cond_b_snapshot <= `RCWG_SNAP_B_RST;
        end else begin
            case (acc_b)
                // R4: read of condition b copies it
                rcwg_pkg::RCWG_ACC_RD_COND: begin
                    receive_cond_b_snapshot <= rcv_b_in;
                end
                // R7: direct write at 1Dh
                rcwg_pkg::RCWG_ACC_WR_SNAP: begin
                    receive_cond_b_snapshot <= cbus_req_in.wdata;
                end
                default: begin
                    receive_cond_b_snapshot <= receive_cond_b_snapshot;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // snapshot read-back
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= `RCWG_RDATA_RST;
            rdata_hit_out <= 1'b0;
        end else begin
            // R6: snapshot a always readable
            if (acc_a == rcwg_pkg::RCWG_ACC_RD_SNAP) begin
                rdata_out <= receive_cond_a_snapshot;
                rdata_hit_out <= 1'b1;
            // R7: snapshot b always readable
            end else if (acc_b == rcwg_pkg::RCWG_ACC_RD_SNAP) begin
                rdata_out <= receive_cond_b_snapshot;
                rdata_hit_out <= 1'b1;
            end else begin
                rdata_out <= `RCWG_RDATA_RST;
                rdata_hit_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // guarded writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rcv_a_wr_out <= '0;
        end else begin
            // R3: blocked bits leave the mask
            rcv_a_wr_out.wr <= (acc_a == rcwg_pkg::RCWG_ACC_WR_COND);
            rcv_a_wr_out.mask <= ~mismatch_a;
            rcv_a_wr_out.data <= next_data_a;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rcv_b_wr_out <= '0;
        end else begin
            // R5: blocked bits leave the mask
            rcv_b_wr_out.wr <= (acc_b == rcwg_pkg::RCWG_ACC_WR_COND);
            rcv_b_wr_out.mask <= ~mismatch_b;
            rcv_b_wr_out.data <= next_data_b;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            write_inhibit_set_out <= 1'b0;
        end else begin
            // R3: inhibit flag on any blocked bit
            write_inhibit_set_out <=
                ((acc_a == rcwg_pkg::RCWG_ACC_WR_COND) && |mismatch_a) ||
                ((acc_b == rcwg_pkg::RCWG_ACC_WR_COND) && |mismatch_b);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_snap_a_load;
        @(posedge clk_in) disable iff (!rstn_in)
        (cbus_req_in.sel && !cbus_req_in.wr &&
         cbus_req_in.addr == `RCWG_ADDR_COND_A)
        |=> receive_cond_a_snapshot == $past(rcv_a_in);
    endproperty
    a_snap_a_load: assert property (p_snap_a_load) // R2
        else $error("snapshot a not loaded on read");

    property p_snap_b_load;
        @(posedge clk_in) disable iff (!rstn_in)
        (cbus_req_in.sel && !cbus_req_in.wr &&
         cbus_req_in.addr == `RCWG_ADDR_COND_B)
        |=> receive_cond_b_snapshot == $past(rcv_b_in);
    endproperty
    a_snap_b_load: assert property (p_snap_b_load) // R4
        else $error("snapshot b not loaded on read");

    property p_inhibit_a;
        @(posedge clk_in) disable iff (!rstn_in)
        (cbus_req_in.sel && cbus_req_in.wr &&
         cbus_req_in.addr == `RCWG_ADDR_COND_A &&
         rcv_a_in != receive_cond_a_snapshot)
        |=> write_inhibit_set_out ##1
            (!write_inhibit_set_out ||
             $past(cbus_req_in.sel && cbus_req_in.wr));
    endproperty
    a_inhibit_a: assert property (p_inhibit_a) // R3
        else $error("inhibit flag not raised for a");

    property p_mask_b;
        @(posedge clk_in) disable iff (!rstn_in)
        (cbus_req_in.sel && cbus_req_in.wr &&
         cbus_req_in.addr == `RCWG_ADDR_COND_B)
        |=> rcv_b_wr_out.wr &&
            rcv_b_wr_out.mask ==
                ~($past(rcv_b_in) ^ $past(receive_cond_b_snapshot)) &&
            (write_inhibit_set_out == (rcv_b_wr_out.mask != 8'hFF));
    endproperty
    a_mask_b: assert property (p_mask_b) // R5
        else $error("guarded write b mask wrong");

    property p_snap_a_rw;
        @(posedge clk_in) disable iff (!rstn_in)
        (cbus_req_in.sel && cbus_req_in.wr &&
         cbus_req_in.addr == `RCWG_ADDR_SNAP_A)
        ##1 (cbus_req_in.sel && !cbus_req_in.wr &&
             cbus_req_in.addr == `RCWG_ADDR_SNAP_A)
        |=> rdata_hit_out && rdata_out == $past(cbus_req_in.wdata, 2);
    endproperty
    a_snap_a_rw: assert property (p_snap_a_rw) // R6
        else $error("snapshot a write then read mismatch");

    property p_snap_b_rd;
        @(posedge clk_in) disable iff (!rstn_in)
        (cbus_req_in.sel && !cbus_req_in.wr &&
         cbus_req_in.addr == `RCWG_ADDR_SNAP_B)
        |=> rdata_hit_out && rdata_out == $past(receive_cond_b_snapshot);
    endproperty
    a_snap_b_rd: assert property (p_snap_b_rd) // R7
        else $error("snapshot b read-back wrong");

    property p_resv_b;
        @(posedge clk_in) disable iff (!rstn_in)
        (cbus_req_in.sel && cbus_req_in.wr &&
         cbus_req_in.addr == `RCWG_ADDR_COND_B &&
         rcv_b_in[`RCWG_RESV_BIT_B] !=
             receive_cond_b_snapshot[`RCWG_RESV_BIT_B])
        |=> !rcv_b_wr_out.mask[`RCWG_RESV_BIT_B] && write_inhibit_set_out;
    endproperty
    a_resv_b: assert property (p_resv_b) // R8
        else $error("reserved bit of b not guarded");

    property p_merge_a;
        @(posedge clk_in) disable iff (!rstn_in)
        (cbus_req_in.sel && cbus_req_in.wr &&
         cbus_req_in.addr == `RCWG_ADDR_COND_A)
        |=> rcv_a_wr_out.data ==
            (($past(cbus_req_in.wdata) & rcv_a_wr_out.mask) |
             ($past(rcv_a_in) & ~rcv_a_wr_out.mask));
    endproperty
    a_merge_a: assert property (p_merge_a) // R9
        else $error("merged data for a wrong");

endmodule
`default_nettype wire

/* File: tb/rcwg_host.sv */
// host processor model that drives the control bus
`timescale 1ns/1ps
`default_nettype none

module rcwg_host (
    input wire logic clk_in,
    output var rcwg_pkg::rcwg_cbus_req_t cbus_req_out
);
    initial begin
        cbus_req_out = '0;
    end

    // ----------------------------------------------------------------
    // one access per cycle, called just after a rising edge
    // ----------------------------------------------------------------
    task cyc(input logic sel, input logic wr, input logic [5:0] addr,
             input logic [7:0] wdata);
        if (sel) begin
            cbus_req_out = '{sel: 1'b1, wr: wr, addr: addr, wdata: wdata};
        end else begin
            // released bus lines stop showing the last value
            cbus_req_out.sel = 1'b0;
            cbus_req_out.wr = ~cbus_req_out.wr;
            cbus_req_out.addr = ~cbus_req_out.addr;
            cbus_req_out.wdata = ~cbus_req_out.wdata;
        end
    endtask
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the receive condition write guard
`timescale 1ns/1ps
`default_nettype none
`include "rcwg_params.svh"

module testbench;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] rcv_a = 8'h00;
    logic [7:0] rcv_b = 8'h00;
    logic [7:0] rdata;
    logic hit;
    logic inh;
    rcwg_pkg::rcwg_cbus_req_t req;
    rcwg_pkg::rcwg_cond_wr_t a_wr;
    rcwg_pkg::rcwg_cond_wr_t b_wr;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int snap_a = 0;
    int snap_b = 0;
    int e_hit = 0, e_rd = 0, e_awr = 0, e_bwr = 0, e_inh = 0;
    int e_am = 0, e_ad = 0, e_bm = 0, e_bd = 0;
    logic [31:0] seed = 32'hCDBE264E;
    logic [5:0] addr_tab [6] = '{`RCWG_ADDR_COND_A, `RCWG_ADDR_COND_B,
        `RCWG_ADDR_SNAP_A, `RCWG_ADDR_SNAP_B, 6'h12, 6'h3F};

    always #25 clk_in = ~clk_in;

    rcwg_host host_u (.clk_in(clk_in), .cbus_req_out(req));

    rcwg_guard dut_u (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .cbus_req_in(req),
        .rcv_a_in(rcv_a),
        .rcv_b_in(rcv_b),
        .rdata_out(rdata),
        .rdata_hit_out(hit),
        .rcv_a_wr_out(a_wr),
        .rcv_b_wr_out(b_wr),
        .write_inhibit_set_out(inh)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic wrap_up();
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string msg);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic step();
        repeat (8) seed = lfsr(seed);
    endtask

    // check the previous access, then issue one and predict its answer
    task automatic op(input logic sel, input logic wr, input logic [5:0] addr,
                      input logic [7:0] wdata, input logic [7:0] la,
                      input logic [7:0] lb);
        int ma;
        int mb;
        @(posedge clk_in);
        #1;
        check(rdata, 8'(e_rd), "snapshot read data");
        check({7'h00, hit}, 8'(e_hit), "snapshot read strobe");
        check({7'h00, a_wr.wr}, 8'(e_awr), "write a strobe");
        check({7'h00, b_wr.wr}, 8'(e_bwr), "write b strobe");
        check({7'h00, inh}, 8'(e_inh), "inhibit pulse");
        if (e_awr != 0) begin
            check(a_wr.mask, 8'(e_am), "write a mask");
            check(a_wr.data, 8'(e_ad), "write a data");
        end
        if (e_bwr != 0) begin
            check(b_wr.mask, 8'(e_bm), "write b mask");
            check(b_wr.data, 8'(e_bd), "write b data");
        end
        rcv_a = la;
        rcv_b = lb;
        host_u.cyc(sel, wr, addr, wdata);
        ma = ~(int'(la) ^ snap_a) & 255;
        mb = ~(int'(lb) ^ snap_b) & 255;
        e_hit = sel && !wr && (addr == `RCWG_ADDR_SNAP_A
                               || addr == `RCWG_ADDR_SNAP_B);
        e_rd = (e_hit == 0) ? 0 : (addr == `RCWG_ADDR_SNAP_A) ? snap_a : snap_b;
        e_awr = sel && wr && addr == `RCWG_ADDR_COND_A;
        e_bwr = sel && wr && addr == `RCWG_ADDR_COND_B;
        e_am = ma;
        e_ad = (int'(wdata) & ma) | (int'(la) & ~ma);
        e_bm = mb;
        e_bd = (int'(wdata) & mb) | (int'(lb) & ~mb);
        e_inh = (e_awr != 0 && ma != 255) || (e_bwr != 0 && mb != 255);
        if (sel && !wr && addr == `RCWG_ADDR_COND_A) snap_a = la;
        if (sel && !wr && addr == `RCWG_ADDR_COND_B) snap_b = lb;
        if (sel && wr && addr == `RCWG_ADDR_SNAP_A) snap_a = wdata;
        if (sel && wr && addr == `RCWG_ADDR_SNAP_B) snap_b = wdata;
    endtask

    // ----------------------------------------------------------------
    // watchdog and main sequence
    // ----------------------------------------------------------------
    always @(posedge clk_in) begin
        cycles++;
        if (cycles > 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (4) @(posedge clk_in);
        #1;
        rstn_in = 1'b1;
        op(1'b1, 1'b0, `RCWG_ADDR_SNAP_A, 8'h00, 8'h00, 8'h00);
        op(1'b1, 1'b0, `RCWG_ADDR_SNAP_B, 8'h00, 8'h00, 8'h00);
        // every access kind, write before read, unmapped places included
        for (int i = 0; i < 12; i++) begin
            step();
            op(1'b1, !i[0], addr_tab[i / 2], seed[7:0], seed[15:8],
               seed[23:16]);
        end
        // read first, then guarded write back to back
        for (int i = 0; i < 16; i++) begin
            step();
            op(1'b1, 1'b0, addr_tab[i % 2], 8'h00, seed[7:0], seed[15:8]);
            op(1'b1, 1'b1, addr_tab[i % 2], seed[23:16],
               seed[7:0] ^ (i < 4 ? 8'h00 : seed[31:24]),
               seed[15:8] ^ (i < 4 ? 8'h00 : {4'h8, seed[27:24]}));
        end
        // random traffic with live values that sometimes hold
        for (int i = 0; i < 400; i++) begin
            step();
            op(seed[0] | seed[1], seed[2], addr_tab[seed[5:3] % 6], seed[15:8],
               seed[6] ? rcv_a : seed[23:16], seed[7] ? rcv_b : seed[31:24]);
        end
        // second reset in mid-run clears both snapshots
        op(1'b0, 1'b0, 6'h00, 8'h00, rcv_a, rcv_b);
        rstn_in = 1'b0;
        snap_a = 0;
        snap_b = 0;
        op(1'b0, 1'b0, 6'h00, 8'h00, rcv_a, rcv_b);
        op(1'b0, 1'b0, 6'h00, 8'h00, rcv_a, rcv_b);
        rstn_in = 1'b1;
        op(1'b1, 1'b0, `RCWG_ADDR_SNAP_A, 8'h00, rcv_a, rcv_b);
        op(1'b1, 1'b0, `RCWG_ADDR_SNAP_B, 8'h00, rcv_a, rcv_b);
        op(1'b0, 1'b0, 6'h00, 8'h00, rcv_a, rcv_b);
        op(1'b0, 1'b0, 6'h00, 8'h00, rcv_a, rcv_b);
        wrap_up();
    end
endmodule

`default_nettype wire
